//--- rtl/clk_sel_pkg.sv
// constants, types and helper functions for the switching clock selector
// assumes a 50 MHz system clock and 32-bit word-aligned APB registers
package clk_sel_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // divisor base: 8 MHz expressed in kHz, and the system clock in kHz
  localparam logic [13:0] REF_KHZ = 14'h1f40;
  localparam logic [15:0] ACC_INC = 16'h1f40;
  localparam logic [15:0] ACC_MOD = 16'hc350;
  localparam logic [5:0] DIV_MIN = 6'h06;
  localparam logic [5:0] DIV_MAX = 6'h28;
  localparam logic [5:0] DIV_RST = 6'h14;
  localparam logic [5:0] DIV_LOW = 6'h28;
  localparam logic [5:0] DIV_OPEN = 6'h14;
  localparam logic [5:0] DIV_HIGH = 6'h08;
  localparam logic [10:0] KHZ_MIN = 11'h0c8;
  localparam logic [10:0] KHZ_MAX = 11'h535;
  localparam logic [10:0] KHZ_RST = 11'h190;
  // external clock period limits and timeouts
  localparam int unsigned EXT_PER_MIN_NS = 714;
  localparam int unsigned EXT_PER_MAX_NS = 5000;
  localparam int unsigned DETECT_TIME_NS = 10000;
  localparam int unsigned LOSS_TIME_NS = 10000;
  localparam logic [9:0] EXT_PER_MIN_CYC = 10'(EXT_PER_MIN_NS / CLK_PERIOD_NS);
  localparam logic [9:0] EXT_PER_MAX_CYC = 10'(EXT_PER_MAX_NS / CLK_PERIOD_NS);
  localparam logic [9:0] DETECT_CYC =
    10'((DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] LOSS_CYC = 10'(LOSS_TIME_NS / CLK_PERIOD_NS);
  // register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_FREQ = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_RATE = 12'h00c;
  // pin mode field values
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_INPUT = 2'h1;
  localparam logic [1:0] MODE_OUTPUT = 2'h2;
  localparam logic [1:0] MODE_RST = 2'h0;
  // strap level codes from the pin sense circuit
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [1:0] STRAP_RES = 2'h3;
  localparam int unsigned RES_ENTRIES = 19;
  // divisor per strap resistor index, 10 kOhm first
  localparam logic [5:0] RES_DIV [RES_ENTRIES] = '{
    6'h28, 6'h24, 6'h21, 6'h1e, 6'h1b, 6'h19, 6'h16, 6'h14, 6'h13, 6'h11,
    6'h0f, 6'h0e, 6'h0d, 6'h0b, 6'h0a, 6'h09, 6'h08, 6'h07, 6'h06};

  typedef enum logic [1:0] {ST_IDLE, ST_DETECT, ST_LOCKED, ST_FREE} sel_st_t;

  function automatic logic [5:0] khz_to_div(input logic [10:0] khz);
    logic [10:0] k;
    logic [13:0] q;
    k = (khz < KHZ_MIN) ? KHZ_MIN : ((khz > KHZ_MAX) ? KHZ_MAX : khz);
    q = 14'((REF_KHZ + 14'(k >> 1)) / 14'(k));
    return q[5:0];
  endfunction

  function automatic logic [10:0] div_to_khz(input logic [5:0] div);
    logic [13:0] q;
    q = 14'((REF_KHZ + 14'(div >> 1)) / 14'(div));
    return q[10:0];
  endfunction

  function automatic logic [5:0] per_to_div(input logic [9:0] per);
    logic [11:0] q;
    q = 12'(({2'h0, per} * 12'h004 + 12'h00c) / 12'h019);
    if (q < 12'(DIV_MIN))
      q = 12'(DIV_MIN);
    if (q > 12'(DIV_MAX))
      q = 12'(DIV_MAX);
    return q[5:0];
  endfunction
endpackage

//--- rtl/osc_if.sv
// link between the selector and its internal rate oscillator
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface osc_if;
  logic [5:0] div;
  logic run;
  logic resync;
  logic sw_clk;
  logic cycle_start;
  modport ctrl (output div, output run, output resync,
                input sw_clk, input cycle_start);
  modport osc (input div, input run, input resync,
               output sw_clk, output cycle_start);
endinterface
`default_nettype wire

//--- rtl/rate_osc.sv
// internal oscillator: 8 MHz tick from the system clock, divided by N
// assumes div stays within 6..40 while run is high
`timescale 1ns/1ps
`default_nettype none
module rate_osc
  import clk_sel_pkg::*;
(
  input wire logic i_mclk, // system clock
  input wire logic i_sys_rst, // synchronous reset, high
  osc_if.osc o_osc // control and clock out
);
  typedef struct packed {
    logic [15:0] acc;
    logic [5:0] cnt;
    logic clk;
    logic start;
  } osc_state_t;

  osc_state_t s_q;
  osc_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.start = 1'b0;
    if (!o_osc.run)
    begin
      s_d.acc = 16'h0000;
      s_d.cnt = 6'h00;
      s_d.clk = 1'b0;
    end
    else if (o_osc.resync)
    begin
      // restart the period on the external rising edge
      s_d.acc = 16'h0000;
      s_d.cnt = 6'h00;
      s_d.clk = 1'b1;
      s_d.start = 1'b1;
    end
    else
    begin
      if (16'(s_q.acc + ACC_INC) >= ACC_MOD)
      begin
        s_d.acc = 16'(s_q.acc + ACC_INC - ACC_MOD);
        if (s_q.cnt >= 6'(o_osc.div - 6'h01))
        begin
          s_d.cnt = 6'h00;
          s_d.start = 1'b1;
        end
        else
          s_d.cnt = 6'(s_q.cnt + 6'h01);
      end
      else
        s_d.acc = 16'(s_q.acc + ACC_INC);
      s_d.clk = (s_d.cnt < (o_osc.div >> 1));
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign o_osc.sw_clk = s_q.clk;
  assign o_osc.cycle_start = s_q.start;

  AST_RESYNC_ALIGN: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (o_osc.run && o_osc.resync) |=>
      (s_q.start && s_q.clk && s_q.cnt == 6'h00))
    else $error("resync did not restart the oscillator period");
endmodule
`default_nettype wire

//--- rtl/switching_clock_select_sync.sv
// switching clock source selection, external clock detect and lock
// assumes synchronous pin inputs and an APB master on the same clock
// Notes on behaviour
// - switching clock comes from one oscillator, referenced internally or externally.
// - output mode drives the internal oscillator, 400 kHz default, onto the pin.
// - output mode never watches the pin for an incoming clock.
// - input mode looks for an external clock at every turn-on.
// - a found external clock aligns the oscillator to its rising edges.
// - lost external clock falls back to internal near the last measured rate.
// - auto mode looks for a clock after turn-on and locks if present.
// - auto mode without clock or software rate uses strap: low 200k, open 400k, high 1M, resistor.
// - strap is sampled once after each reset release, later changes ignored.
// - strap resistor index decodes to nineteen rates, 200 to 1333 kHz.
// - software rate 200 kHz to 1.33 MHz, divisor 6 to 40 of 8 MHz.
// - off-grid requested rate rounds to the nearest whole divisor.
// - rate readback shows the quantized divisor, not the nominal value.
`timescale 1ns/1ps
`default_nettype none
module switching_clock_select_sync
  import clk_sel_pkg::*;
(
  input wire logic i_mclk, // system clock, 50 MHz
  input wire logic i_sys_rst, // synchronous reset, high
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [11:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error on unmapped address
  input wire logic i_enable, // converter turn-on
  input wire logic [1:0] i_strap_level, // pin strap level code
  input wire logic [4:0] i_strap_res_idx, // strap resistor index
  input wire logic i_sync_pin, // shared clock pin, input side
  output logic o_sync_pin, // shared clock pin, output side
  output logic o_sync_oe_n, // shared clock pin drive, low drives
  output logic o_sw_clk, // converter_switch_rate clock
  output logic o_pll_ref_ext // oscillator locked to external clock
);
  typedef struct packed {
    sel_st_t st;
    logic [1:0] mode;
    logic [10:0] req_khz;
    logic [5:0] sw_div;
    logic sw_set;
    logic [5:0] strap_div;
    logic strap_done;
    logic en_prev;
    logic pin_prev;
    logic edge_seen;
    logic [9:0] per_cnt;
    logic [9:0] win_cnt;
    logic [5:0] meas_div;
    logic [5:0] act_div;
    logic [31:0] prdata;
  } sel_state_t;

  sel_state_t s_q;
  sel_state_t s_d;
  osc_if osc_link ();
  logic pin_rise;
  logic en_rise;
  logic wr_acc;
  logic rd_setup;
  logic addr_ok;
  logic per_ok;
  logic [5:0] idle_div;

  rate_osc u_osc (
    .i_mclk (i_mclk),
    .i_sys_rst (i_sys_rst),
    .o_osc (osc_link.osc)
  );

  assign pin_rise = i_sync_pin & ~s_q.pin_prev;
  assign en_rise = i_enable & ~s_q.en_prev;
  assign addr_ok = (i_paddr == REG_CTRL) || (i_paddr == REG_FREQ) ||
                   (i_paddr == REG_STATUS) || (i_paddr == REG_RATE);
  assign wr_acc = i_psel & i_penable & i_pwrite;
  assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
  assign per_ok = s_q.edge_seen && (s_q.per_cnt >= EXT_PER_MIN_CYC) &&
                  (s_q.per_cnt <= EXT_PER_MAX_CYC);
  // auto mode uses the strap unless software has chosen a rate
  assign idle_div = (s_q.mode == MODE_AUTO && !s_q.sw_set) ?
                    s_q.strap_div : s_q.sw_div;

  always_comb
  begin
    s_d = s_q;
    s_d.en_prev = i_enable;
    s_d.pin_prev = i_sync_pin;

    // strap sense, once after reset release only
    if (!s_q.strap_done)
    begin
      s_d.strap_done = 1'b1;
      case (i_strap_level)
        STRAP_LOW: s_d.strap_div = DIV_LOW;
        STRAP_OPEN: s_d.strap_div = DIV_OPEN;
        STRAP_HIGH: s_d.strap_div = DIV_HIGH;
        default:
        begin
          if (i_strap_res_idx < 5'(RES_ENTRIES))
            s_d.strap_div = RES_DIV[i_strap_res_idx];
          else
            s_d.strap_div = DIV_OPEN;
        end
      endcase
    end

    // register writes take effect in the access phase
    if (wr_acc)
    begin
      if (i_paddr == REG_CTRL)
      begin
        if (i_pwdata[1:0] == MODE_INPUT || i_pwdata[1:0] == MODE_OUTPUT)
          s_d.mode = i_pwdata[1:0];
        else
          s_d.mode = MODE_AUTO;
      end
      else if (i_paddr == REG_FREQ)
      begin
        s_d.req_khz = i_pwdata[10:0];
        s_d.sw_div = khz_to_div(i_pwdata[10:0]);
        s_d.sw_set = 1'b1;
      end
    end

    // read data is captured in the setup phase
    if (rd_setup)
    begin
      case (i_paddr)
        REG_CTRL: s_d.prdata = {30'h0, s_q.mode};
        REG_FREQ: s_d.prdata = {15'h0, s_q.sw_div, 11'(s_q.req_khz)};
        REG_STATUS: s_d.prdata = {20'h0, s_q.strap_done, s_q.sw_set,
                                  s_q.st, 2'h0, s_q.act_div};
        REG_RATE: s_d.prdata = {21'h0, div_to_khz(s_q.act_div)};
        default: s_d.prdata = 32'h0;
      endcase
    end

    case (s_q.st)
      ST_IDLE:
      begin
        s_d.act_div = (s_q.mode == MODE_OUTPUT) ? s_q.sw_div : idle_div;
        if (en_rise && s_q.strap_done)
        begin
          if (s_q.mode == MODE_OUTPUT)
            s_d.st = ST_FREE;
          else
          begin
            s_d.st = ST_DETECT;
            s_d.win_cnt = 10'h000;
            s_d.per_cnt = 10'h000;
            s_d.edge_seen = 1'b0;
          end
        end
      end
      ST_DETECT:
      begin
        s_d.win_cnt = 10'(s_q.win_cnt + 10'h001);
        s_d.per_cnt = 10'(s_q.per_cnt + 10'h001);
        if (pin_rise)
        begin
          s_d.per_cnt = 10'h000;
          s_d.edge_seen = 1'b1;
          if (per_ok)
          begin
            s_d.st = ST_LOCKED;
            s_d.meas_div = per_to_div(s_q.per_cnt);
            s_d.act_div = per_to_div(s_q.per_cnt);
          end
        end
        // a stray edge on the last cycle must not hold the window open
        if (s_d.st == ST_DETECT &&
            s_q.win_cnt >= 10'(DETECT_CYC - 10'h001))
        begin
          s_d.st = ST_FREE;
          s_d.act_div = idle_div;
        end
      end
      ST_LOCKED:
      begin
        s_d.per_cnt = 10'(s_q.per_cnt + 10'h001);
        if (pin_rise)
        begin
          s_d.per_cnt = 10'h000;
          if (per_ok)
          begin
            s_d.meas_div = per_to_div(s_q.per_cnt);
            s_d.act_div = per_to_div(s_q.per_cnt);
          end
        end
        else if (s_q.per_cnt >= 10'(LOSS_CYC - 10'h001))
        begin
          s_d.st = ST_FREE;
          s_d.act_div = s_q.meas_div;
        end
      end
      ST_FREE:
      begin
        if (s_q.mode == MODE_OUTPUT)
          s_d.act_div = s_q.sw_div;
      end
      default:
        s_d.st = ST_IDLE;
    endcase

    // turning off ends the run; entering output mode stops detect or lock and frees the oscillator on sw_div
    if (!i_enable && s_q.st != ST_IDLE)
      s_d.st = ST_IDLE;
    else if (s_q.mode == MODE_OUTPUT &&
             (s_q.st == ST_DETECT || s_q.st == ST_LOCKED))
    begin
      s_d.st = ST_FREE;
      s_d.act_div = s_q.sw_div;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.mode <= MODE_RST;
      s_q.req_khz <= KHZ_RST;
      s_q.sw_div <= DIV_RST;
      s_q.strap_div <= DIV_OPEN;
      s_q.meas_div <= DIV_RST;
      s_q.act_div <= DIV_RST;
    end
    else
      s_q <= s_d;
  end

  // oscillator runs while converting, or always when sourcing the line
  assign osc_link.div = s_q.act_div;
  assign osc_link.run = (s_q.st != ST_IDLE) || (s_q.mode == MODE_OUTPUT);
  assign osc_link.resync = (s_q.st == ST_LOCKED) && pin_rise;

  assign o_sw_clk = osc_link.sw_clk;
  assign o_pll_ref_ext = (s_q.st == ST_LOCKED);
  assign o_sync_pin = (s_q.mode == MODE_OUTPUT) & osc_link.sw_clk;
  assign o_sync_oe_n = (s_q.mode != MODE_OUTPUT);
  assign o_prdata = s_q.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~addr_ok;

  AST_OUT_DRIVES_PIN: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (s_q.mode == MODE_OUTPUT) |-> (!o_sync_oe_n && o_sync_pin == o_sw_clk))
    else $error("output mode does not drive the oscillator on the pin");

  AST_PIN_RELEASED: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (s_q.mode != MODE_OUTPUT) |-> (o_sync_oe_n && !o_sync_pin))
    else $error("pin driven while not the clock source");

  AST_OUT_NO_MONITOR: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (s_q.mode == MODE_OUTPUT && s_d.mode == MODE_OUTPUT) |=>
      (s_q.st != ST_DETECT && s_q.st != ST_LOCKED))
    else $error("pin watched for a clock while sourcing it");

  AST_IDLE_STOPPED: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (s_q.st == ST_IDLE && s_q.mode != MODE_OUTPUT) |=> !o_sw_clk)
    else $error("oscillator ran while the converter was off");

  AST_DETECT_ON_ENABLE: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (s_q.st == ST_IDLE && en_rise && s_q.strap_done && i_enable &&
     s_q.mode != MODE_OUTPUT && !wr_acc) |=>
      (s_q.st == ST_DETECT && s_q.win_cnt == 10'h000))
    else $error("turn-on did not start clock detection");

  AST_RESYNC_START: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    osc_link.resync |=> osc_link.cycle_start)
    else $error("external edge did not start a new period");

  AST_DETECT_BOUND: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (s_q.st == ST_DETECT) |-> (s_q.win_cnt < DETECT_CYC))
    else $error("detection window overran");

  AST_LOCK_NEEDS_EDGE: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    $rose(o_pll_ref_ext) |-> ($past(s_q.edge_seen) && $past(pin_rise)))
    else $error("locked without two external edges");

  AST_LOSS_FALLBACK: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (s_q.st == ST_LOCKED && i_enable && s_q.mode != MODE_OUTPUT &&
     !pin_rise && s_q.per_cnt == 10'(LOSS_CYC - 10'h001)) |=>
      (s_q.st == ST_FREE && s_q.act_div == $past(s_q.meas_div)))
    else $error("lost clock did not fall back to measured rate");

  AST_AUTO_STRAP: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    ($past(s_q.st) == ST_DETECT && s_q.st == ST_FREE &&
     s_q.mode == MODE_AUTO && !s_q.sw_set && $stable(s_q.mode)) |->
      (s_q.act_div == s_q.strap_div))
    else $error("auto mode without clock ignored the strap");

  AST_STRAP_HELD: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    s_q.strap_done |=> (s_q.strap_done && $stable(s_q.strap_div)))
    else $error("strap rate changed after start-up");

  AST_DIV_RANGE: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (s_q.act_div >= DIV_MIN && s_q.act_div <= DIV_MAX &&
     s_q.sw_div >= DIV_MIN && s_q.sw_div <= DIV_MAX))
    else $error("divisor outside 6 to 40");

  AST_FREQ_CLAMP: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (wr_acc && i_paddr == REG_FREQ && i_pwdata[10:0] < KHZ_MIN) |=>
      (s_q.sw_div == DIV_MAX))
    else $error("rate below 200 kHz not clamped to divisor 40");

  AST_FREQ_TOP: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (wr_acc && i_paddr == REG_FREQ && i_pwdata[10:0] > KHZ_MAX) |=>
      (s_q.sw_div == DIV_MIN))
    else $error("rate above 1333 kHz not clamped to divisor 6");

  AST_FREQ_ROUND: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (wr_acc && i_paddr == REG_FREQ && i_pwdata[10:0] == 11'h32a) |=>
      (s_q.sw_div == 6'h0a))
    else $error("810 kHz request did not pick divisor 10");

  AST_RATE_READ: assert property (@(posedge i_mclk)
    disable iff (i_sys_rst)
    (rd_setup && i_paddr == REG_RATE) |=>
      (o_prdata[10:0] == div_to_khz($past(s_q.act_div))))
    else $error("rate readback not the quantized divisor");
endmodule
`default_nettype wire

//--- sim/ext_clk_src.sv
// behavioural external clock source on the shared clock pin
// assumes the bench resolves the pin and pulls it low when released
`timescale 1ns/1ps
`default_nettype none
module ext_clk_src
(
  input wire logic i_mclk, // system clock
  input wire logic i_run, // source enabled
  input wire logic [9:0] i_period, // clock period in system cycles
  output logic o_clk, // clock onto the shared pin
  output logic o_drive // high while driving the pin
);
  logic [9:0] cnt_q;
  // drives whenever run is high; the bench runs it only while the device listens
  assign o_drive = i_run;
  always_ff @(posedge i_mclk)
  begin
    if (!i_run)
    begin
      cnt_q <= 10'h000;
      o_clk <= 1'b0;
    end
    else
    begin
      // bench keeps the period in range and starts before turn-on
      cnt_q <= (cnt_q + 10'h001 >= i_period) ? 10'h000 : cnt_q + 10'h001;
      o_clk <= (cnt_q < (i_period >> 1));
    end
  end
endmodule
`default_nettype wire

//--- sim/switching_clock_select_sync_tb.sv
// self-checking bench for the switching clock selector
// assumes the external clock source model and a zero-wait apb slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("wrong value at %0t: got %h exp %h", $time, got, exp); \
    end \
  end
module switching_clock_select_sync_tb;
  import clk_sel_pkg::*;
  typedef struct packed {logic strap; logic [1:0] lvl; logic [4:0] idx;
    logic [10:0] khz; logic [5:0] div;} row_t;
  localparam row_t ROWS [13] = '{
    '{1'b1, STRAP_LOW, 5'h00, 11'h000, 6'h28},
    '{1'b1, STRAP_OPEN, 5'h00, 11'h000, 6'h14},
    '{1'b1, STRAP_HIGH, 5'h00, 11'h000, 6'h08},
    '{1'b1, STRAP_RES, 5'h00, 11'h000, 6'h28},
    '{1'b1, STRAP_RES, 5'h07, 11'h000, 6'h14},
    '{1'b1, STRAP_RES, 5'h11, 11'h000, 6'h07},
    '{1'b1, STRAP_RES, 5'h12, 11'h000, 6'h06},
    '{1'b1, STRAP_RES, 5'h19, 11'h000, 6'h14},
    '{1'b0, STRAP_OPEN, 5'h00, 11'h096, 6'h28},
    '{1'b0, STRAP_OPEN, 5'h00, 11'h7d0, 6'h06},
    '{1'b0, STRAP_OPEN, 5'h00, 11'h12c, 6'h1b},
    '{1'b0, STRAP_OPEN, 5'h00, 11'h1f4, 6'h10},
    '{1'b0, STRAP_OPEN, 5'h00, 11'h32a, 6'h0a}};
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [1:0] strap_level;
  logic [4:0] strap_res_idx;
  logic pin_in, pin_out, pin_oe_n, sw_clk, ref_ext, err, pin_last;
  logic src_run, src_clk, src_drive;
  logic [9:0] src_period;
  logic [7:0] seen;
  int num_errors = 0;
  int checks_done = 0;
  int edges;
  // shared line has a pull-down when nobody drives it
  assign pin_in = !pin_oe_n ? pin_out : (src_drive ? src_clk : 1'b0);
  switching_clock_select_sync u_dut (.i_mclk(mclk), .i_sys_rst(sys_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_enable(enable), .i_strap_level(strap_level),
    .i_strap_res_idx(strap_res_idx), .i_sync_pin(pin_in),
    .o_sync_pin(pin_out), .o_sync_oe_n(pin_oe_n), .o_sw_clk(sw_clk),
    .o_pll_ref_ext(ref_ext));
  ext_clk_src u_src (.i_mclk(mclk), .i_run(src_run), .i_period(src_period),
    .o_clk(src_clk), .o_drive(src_drive));
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic turn_on();
    enable <= 1'b0;
    @(posedge mclk);
    enable <= 1'b1;
    repeat (600) @(posedge mclk);
  endtask
  initial
  begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, enable, src_run} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    strap_level = STRAP_OPEN;
    strap_res_idx = 5'h00;
    src_period = 10'd100;
    do_reset();
    for (int i = 0; i < 13; i++)
    begin
      if (ROWS[i].strap)
      begin
        strap_level <= ROWS[i].lvl;
        strap_res_idx <= ROWS[i].idx;
        do_reset();
        turn_on();
        apb(1'b0, REG_STATUS, 32'h0);
      end
      else
      begin
        apb(1'b1, REG_FREQ, {21'h0, ROWS[i].khz});
        apb(1'b0, REG_FREQ, 32'h0);
      end
      seen = ROWS[i].strap ? {rdata[9:8], rdata[5:0]} : {2'h3, rdata[16:11]};
      `CHK(seen, {2'h3, ROWS[i].div})
    end
    turn_on();
    apb(1'b0, REG_RATE, 32'h0);
    `CHK(rdata, 32'h320)
    strap_level <= STRAP_OPEN;
    do_reset();
    `CHK({ref_ext, pin_oe_n, sw_clk}, 3'b010)
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rdata[9:0], 10'h014)
    apb(1'b0, 12'h010, 32'h0);
    `CHK({err, pready, rdata}, {2'b11, 32'h0})
    apb(1'b1, REG_CTRL, 32'h2);
    apb(1'b1, REG_CTRL, 32'h3);
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK(rdata, {30'h0, MODE_AUTO})
    // own clock loops back on the pin and must not be locked to
    apb(1'b1, REG_CTRL, 32'h2);
    turn_on();
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK({ref_ext, pin_oe_n, rdata[9:8]}, {2'b00, 2'h3})
    edges = 0;
    pin_last = pin_out;
    repeat (5000)
    begin
      @(posedge mclk);
      if (pin_out && !pin_last)
        edges++;
      pin_last = pin_out;
    end
    `CHK(edges inside {[39:41]}, 1'b1)
    strap_level <= STRAP_LOW;
    do_reset();
    strap_level <= STRAP_HIGH;
    turn_on();
    turn_on();
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(rdata[5:0], 6'h28)
    apb(1'b1, REG_FREQ, 32'h1f4);
    apb(1'b1, REG_CTRL, 32'h1);
    src_run <= 1'b1;
    repeat (20) @(posedge mclk);
    turn_on();
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK({ref_ext, rdata[9:8], rdata[5:0]}, {1'b1, 2'h2, 6'h10})
    @(posedge src_clk);
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    `CHK(sw_clk, 1'b1)
    repeat (54) @(posedge mclk);
    @(negedge mclk);
    `CHK(sw_clk, 1'b0)
    @(posedge mclk);
    src_run <= 1'b0;
    repeat (600) @(posedge mclk);
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK({ref_ext, rdata[9:8], rdata[5:0]}, {1'b0, 2'h3, 6'h10})
    apb(1'b1, REG_CTRL, 32'h0);
    src_period <= 10'd50;
    src_run <= 1'b1;
    repeat (20) @(posedge mclk);
    turn_on();
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK({ref_ext, rdata[9:8], rdata[5:0]}, {1'b1, 2'h2, 6'h08})
    wrap_up();
  end
endmodule
`default_nettype wire
